// *** logic/clock_ratio_pkg.sv ***
// constants for the power-up clock configuration decoder
// assumes the configuration word is presented bit-indexed, bit 0 first
package clock_ratio_pkg;
  localparam int CFG_W = 512;
  // field positions, first (most significant) bit of each field
  localparam int PLATFORM_MULT_POS = 2;
  localparam int CLUSTER_MULT_POS = 26;
  localparam int CLUSTER_STRIDE = 8;
  localparam int CLUSTER_CFG_OFS = 5;
  localparam int DDR_CFG_POS = 8;
  localparam int DDR_MULT_POS = 10;
  localparam int CORE_SEL_POS = 64;
  localparam int CORE_SEL_W = 4;
  localparam int PE_SEL_POS = 80;
  localparam int SERDES_MULT_POS = 88;
  localparam int SERDES_MULT_W = 3;
  localparam int SERDES_B1_DIV_POS = 100;
  localparam int SERDES_B1_DIV_W = 5;
  localparam int SERDES_BN_DIV_POS = 105;
  localparam int DDR_SYNC_BIT = 184;
  localparam int DDR_RATE_BIT = 232;
  localparam int DDR_RSV_BIT = 234;
  localparam int MULT_W = 5;
  localparam int CFG2_W = 2;
  // legal encodings, one mask bit per binary value
  localparam logic [31:0] PLATFORM_MASK = 32'h0000_01e0;
  localparam logic [31:0] CLUSTER_MASK = 32'h0057_df00;
  localparam logic [31:0] DDR_ASYNC_MASK = 32'h011d_3760;
  localparam logic [31:0] DDR_SYNC_MASK = 32'h0000_0002;
  localparam logic [4:0] DDR_SYNC_MULT = 5'h01;
  // pll range configuration codes
  localparam logic [1:0] CFG_00 = 2'h0;
  localparam logic [1:0] CFG_01 = 2'h1;
  localparam logic [1:0] CFG_10 = 2'h2;
  localparam logic [1:0] CFG_11 = 2'h3;
  // error vector bit positions
  localparam int ERR_W = 8;
  localparam int E_PLAT = 0;
  localparam int E_CLMULT = 1;
  localparam int E_CLCFG = 2;
  localparam int E_CORE = 3;
  localparam int E_ORDER = 4;
  localparam int E_DDRM = 5;
  localparam int E_DDRC = 6;
  localparam int E_DDRB = 7;
  localparam logic [7:0] LB_DIV_RESET = 8'h01;
endpackage

// *** logic/mult_dec_if.sv ***
// carrier between a raw multiplier field and its decoder
// assumes both ends are combinational and share no clock
`timescale 1ns/1ps
`default_nettype none
interface mult_dec_if;
  logic [4:0] field;
  logic [4:0] mult;
  logic valid;
  modport src (output field, input mult, input valid);
  modport dec (input field, output mult, output valid);
endinterface
`default_nettype wire

// *** logic/ratio_field_decode.sv ***
// decodes a five-bit ratio field whose binary value is the multiplier
// assumes the legal set is given as a 32-bit mask
`timescale 1ns/1ps
`default_nettype none
module ratio_field_decode #(
  parameter logic [31:0] VALID_MASK = 32'h0000_0000
) (
  mult_dec_if.dec port
);
  // legal codes pass through, reserved ones read as zero
  assign port.valid = VALID_MASK[port.field];
  assign port.mult = port.valid ? port.field : 5'h00;
endmodule
`default_nettype wire

// *** logic/reset_config_clock_ratio_decoder.sv ***
// latches and decodes the clock fields of the power-up configuration word
// assumes clk is the platform clock and the word is steady at reset release
// Function
// - platform multiplier codes 5..8 give ratios 5..8, others reserved
// - cluster and packet-engine multiplier is the field's value, listed set only
// - three ratio fields: two cluster plls and packet-engine pll, fixed at power-up
// - core select 0000/0001 pll one /1 or /2, 0100/0101 pll two
// - both memory controllers share one frequency configuration
// - word bit 184 picks memory clock: zero asynchronous, one synchronous
// - asynchronous memory multiplier is the field's value, listed set only
// - synchronous memory multiplier must be one with pll range 01
// - synchronous memory bus clock runs at half the platform clock
// - local bus clock is platform clock divided by the divider field
// - packet-engine pll references platform when its select bit is zero, third cluster pll otherwise
// - each serdes bank pll has its own ratio and per-lane-group divider
// - packet-engine select zero picks platform clock halved, one its pll halved
// - first bank divider has five bits, one per lane pair, one divides by two
// - banks two to four have one divider bit for all four lanes
`timescale 1ns/1ps
`default_nettype none
module reset_config_clock_ratio_decoder #(
  parameter int LB_DIV_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [clock_ratio_pkg::CFG_W-1:0] power_up_config_word,
  input wire logic [LB_DIV_W-1:0] local_bus_divider,
  output logic config_valid,
  output logic [4:0] platform_pll_multiplier,
  output logic [2:0][4:0] cluster_pll_multiplier,
  output logic [2:0][1:0] cluster_pll_range_cfg,
  output logic [3:0] core_pll_source_select,
  output logic [3:0] core_clock_halved,
  output logic ddr_sync_mode,
  output logic [4:0] ddr_pll_multiplier,
  output logic [1:0] ddr_pll_range_cfg,
  output logic ddr_ctrl_clk_en,
  output logic local_bus_clock_out,
  output logic [1:0] packet_engine_clock_select,
  output logic [1:0] packet_engine_clk_en,
  output logic [1:0] packet_engine_pll_ref_platform,
  output logic [3:0][2:0] serdes_bank_multiplier,
  output logic [4:0] serdes_first_bank_divider,
  output logic [2:0] serdes_bank_divider,
  output logic [clock_ratio_pkg::ERR_W-1:0] config_error_flags,
  output logic config_error
);
  // pulls a field, first bit most significant, right-aligned
  function automatic logic [4:0] cfg_field(input logic [clock_ratio_pkg::CFG_W-1:0] w, input int pos, input int len);
    logic [4:0] r;
    r = 5'h00;
    for (int k = 0; k < 5; k++)
    begin
      if (k < len)
      begin
        r[k] = w[pos + len - 1 - k];
      end
    end
    return r;
  endfunction

  logic cap_q;
  logic half_q;
  logic [LB_DIV_W-1:0] lb_cnt_q;
  logic lb_en_q;
  logic [4:0] plat_q;
  logic [2:0][4:0] cl_q;
  logic [2:0][1:0] clcfg_q;
  logic [3:0] src_q;
  logic [3:0] div2_q;
  logic sync_q;
  logic [4:0] ddrm_q;
  logic [1:0] ddrc_q;
  logic [1:0] pesel_q;
  logic [3:0][2:0] sdm_q;
  logic [4:0] sdb1_q;
  logic [2:0] sdbn_q;
  logic [clock_ratio_pkg::ERR_W-1:0] err_q;
  logic [clock_ratio_pkg::ERR_W-1:0] err_d;

  // multiplier decoders, one per cluster pll and the packet-engine pll
  logic [2:0][4:0] cl_mult;
  logic [2:0] cl_valid;
  logic [2:0][1:0] cl_cfg;
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gen_cluster
      mult_dec_if cl_if ();
      assign cl_if.field = cfg_field(power_up_config_word,
        clock_ratio_pkg::CLUSTER_MULT_POS + g * clock_ratio_pkg::CLUSTER_STRIDE, clock_ratio_pkg::MULT_W);
      ratio_field_decode #(.VALID_MASK(clock_ratio_pkg::CLUSTER_MASK)) u_dec (.port(cl_if));
      assign cl_mult[g] = cl_if.mult;
      assign cl_valid[g] = cl_if.valid;
      assign cl_cfg[g] = 2'(cfg_field(power_up_config_word, clock_ratio_pkg::CLUSTER_MULT_POS
        + g * clock_ratio_pkg::CLUSTER_STRIDE + clock_ratio_pkg::CLUSTER_CFG_OFS, clock_ratio_pkg::CFG2_W));
    end
  endgenerate

  // platform and memory multiplier decoders
  mult_dec_if plat_if ();
  mult_dec_if ddra_if ();
  mult_dec_if ddrs_if ();
  logic [4:0] ddr_raw;
  assign ddr_raw = cfg_field(power_up_config_word, clock_ratio_pkg::DDR_MULT_POS, clock_ratio_pkg::MULT_W);
  assign plat_if.field = cfg_field(power_up_config_word, clock_ratio_pkg::PLATFORM_MULT_POS, clock_ratio_pkg::MULT_W);
  assign ddra_if.field = ddr_raw;
  assign ddrs_if.field = ddr_raw;
  ratio_field_decode #(.VALID_MASK(clock_ratio_pkg::PLATFORM_MASK)) u_plat (.port(plat_if));
  ratio_field_decode #(.VALID_MASK(clock_ratio_pkg::DDR_ASYNC_MASK)) u_ddra (.port(ddra_if));
  ratio_field_decode #(.VALID_MASK(clock_ratio_pkg::DDR_SYNC_MASK)) u_ddrs (.port(ddrs_if));

  // memory mode, shared multiplier and range check
  logic sync_d;
  logic [4:0] ddrm_d;
  logic [1:0] ddrc_d;
  logic ddr_cfg_ok;
  assign sync_d = power_up_config_word[clock_ratio_pkg::DDR_SYNC_BIT];
  assign ddrm_d = sync_d ? ddrs_if.mult : ddra_if.mult;
  assign ddrc_d = 2'(cfg_field(power_up_config_word, clock_ratio_pkg::DDR_CFG_POS, clock_ratio_pkg::CFG2_W));
  assign ddr_cfg_ok = sync_d ? (ddrc_d == clock_ratio_pkg::CFG_01) :
    (ddrm_d == 5'h08 || ddrm_d == 5'h09) ? (ddrc_d == clock_ratio_pkg::CFG_10 || ddrc_d == clock_ratio_pkg::CFG_01) :
    (ddrm_d == 5'h06 || ddrm_d == 5'h0c || ddrm_d == 5'h0d || ddrm_d == 5'h10) ? (ddrc_d == clock_ratio_pkg::CFG_11) :
    (ddrm_d == 5'h0a) ? (ddrc_d == clock_ratio_pkg::CFG_01) : 1'b1;

  // per-core source select and pll ordering
  logic [3:0][3:0] csel;
  logic [3:0] csel_bad;
  logic [3:0] order_bad;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_core
      assign csel[g] = 4'(cfg_field(power_up_config_word,
        clock_ratio_pkg::CORE_SEL_POS + g * clock_ratio_pkg::CORE_SEL_W, clock_ratio_pkg::CORE_SEL_W));
      assign csel_bad[g] = csel[g][3] | csel[g][1];
      if (g < 2)
      begin : gen_lo
        assign order_bad[g] = csel[g][2] & (cl_mult[1] >= cl_mult[0]);
      end
      else
      begin : gen_hi
        assign order_bad[g] = ~csel[g][2] & (cl_mult[0] >= cl_mult[1]);
      end
    end
  endgenerate

  // gathered configuration errors
  assign err_d[clock_ratio_pkg::E_PLAT] = ~plat_if.valid;
  assign err_d[clock_ratio_pkg::E_CLMULT] = ~&cl_valid;
  assign err_d[clock_ratio_pkg::E_CLCFG] = cl_cfg[0][0] | cl_cfg[1][0] | cl_cfg[2][0];
  assign err_d[clock_ratio_pkg::E_CORE] = |csel_bad;
  assign err_d[clock_ratio_pkg::E_ORDER] = |order_bad;
  assign err_d[clock_ratio_pkg::E_DDRM] = sync_d ? ~ddrs_if.valid : ~ddra_if.valid;
  assign err_d[clock_ratio_pkg::E_DDRC] = ~ddr_cfg_ok;
  assign err_d[clock_ratio_pkg::E_DDRB] = (power_up_config_word[clock_ratio_pkg::DDR_RATE_BIT] != sync_d)
    | power_up_config_word[clock_ratio_pkg::DDR_RSV_BIT];

  // one-time capture on the first edge after reset release
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cap_q <= 1'b0;
    end
    else
    begin
      cap_q <= 1'b1;
    end
  end

  // field registers, loaded only while capture is pending
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      plat_q <= 5'h00;
      cl_q <= '0;
      clcfg_q <= '0;
      src_q <= 4'h0;
      div2_q <= 4'h0;
      sync_q <= 1'b0;
      ddrm_q <= 5'h00;
      ddrc_q <= 2'h0;
      pesel_q <= 2'h0;
      sdm_q <= '0;
      sdb1_q <= 5'h00;
      sdbn_q <= 3'h0;
      err_q <= '0;
    end
    else if (!cap_q)
    begin
      plat_q <= plat_if.mult;
      cl_q <= cl_mult;
      clcfg_q <= cl_cfg;
      for (int i = 0; i < 4; i++)
      begin
        src_q[i] <= csel[i][2];
        div2_q[i] <= csel[i][0];
        sdm_q[i] <= 3'(cfg_field(power_up_config_word, clock_ratio_pkg::SERDES_MULT_POS
          + i * clock_ratio_pkg::SERDES_MULT_W, clock_ratio_pkg::SERDES_MULT_W));
      end
      sync_q <= sync_d;
      ddrm_q <= ddrm_d;
      ddrc_q <= ddrc_d;
      pesel_q <= 2'(cfg_field(power_up_config_word, clock_ratio_pkg::PE_SEL_POS, 2));
      sdb1_q <= cfg_field(power_up_config_word, clock_ratio_pkg::SERDES_B1_DIV_POS,
        clock_ratio_pkg::SERDES_B1_DIV_W);
      sdbn_q <= 3'(cfg_field(power_up_config_word, clock_ratio_pkg::SERDES_BN_DIV_POS, 3));
      err_q <= err_d;
    end
  end

  // half-rate and local bus enable dividers
  logic [LB_DIV_W-1:0] lb_last;
  assign lb_last = (local_bus_divider == '0) ? '0 : local_bus_divider - 1'b1;
  always_ff @(posedge clk)
  begin
    if (!rst_b || !cap_q)
    begin
      half_q <= 1'b0;
      lb_cnt_q <= '0;
      lb_en_q <= 1'b0;
    end
    else
    begin
      half_q <= ~half_q;
      lb_en_q <= (lb_cnt_q >= lb_last);
      lb_cnt_q <= (lb_cnt_q >= lb_last) ? '0 : lb_cnt_q + 1'b1;
    end
  end

  // outputs
  assign config_valid = cap_q;
  assign platform_pll_multiplier = plat_q;
  assign cluster_pll_multiplier = cl_q;
  assign cluster_pll_range_cfg = clcfg_q;
  assign core_pll_source_select = src_q;
  assign core_clock_halved = div2_q;
  assign ddr_sync_mode = sync_q;
  assign ddr_pll_multiplier = ddrm_q;
  assign ddr_pll_range_cfg = ddrc_q;
  assign ddr_ctrl_clk_en = sync_q & half_q;
  assign local_bus_clock_out = lb_en_q;
  assign packet_engine_clock_select = pesel_q;
  assign packet_engine_clk_en = {2{half_q}} & ~pesel_q;
  assign packet_engine_pll_ref_platform = ~pesel_q;
  assign serdes_bank_multiplier = sdm_q;
  assign serdes_first_bank_divider = sdb1_q;
  assign serdes_bank_divider = sdbn_q;
  assign config_error_flags = err_q;
  assign config_error = |err_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_platform_legal: assert property (cap_q && !err_q[clock_ratio_pkg::E_PLAT] |-> plat_q inside {5'h05, 5'h06, 5'h07, 5'h08})
    else $error("platform multiplier outside legal set");
  a_cluster_legal: assert property (cap_q && !err_q[clock_ratio_pkg::E_CLMULT] |-> clock_ratio_pkg::CLUSTER_MASK[cl_q[0]]
    && clock_ratio_pkg::CLUSTER_MASK[cl_q[1]] && clock_ratio_pkg::CLUSTER_MASK[cl_q[2]])
    else $error("cluster multiplier outside legal set");
  a_fields_held: assert property (cap_q && $past(cap_q) |-> $stable(plat_q) && $stable(cl_q) && $stable(ddrm_q)
    && $stable(err_q) && $stable(src_q))
    else $error("latched field changed after capture");
  a_core_order: assert property (cap_q && src_q[0] && !err_q[clock_ratio_pkg::E_ORDER] |-> cl_q[1] < cl_q[0])
    else $error("core ordering error not flagged");
  a_ddr_sync_ratio: assert property (cap_q && sync_q && !err_q[clock_ratio_pkg::E_DDRM] && !err_q[clock_ratio_pkg::E_DDRC]
    |-> ddrm_q == clock_ratio_pkg::DDR_SYNC_MULT && ddrc_q == clock_ratio_pkg::CFG_01)
    else $error("synchronous memory setting accepted wrongly");
  a_ddr_async_legal: assert property (cap_q && !sync_q && !err_q[clock_ratio_pkg::E_DDRM]
    |-> clock_ratio_pkg::DDR_ASYNC_MASK[ddrm_q])
    else $error("asynchronous memory multiplier illegal");
  a_mem_half_rate: assert property (sync_q && ddr_ctrl_clk_en |=> !ddr_ctrl_clk_en ##1 ddr_ctrl_clk_en)
    else $error("memory enable not at half rate");
  a_async_no_en: assert property (cap_q && !sync_q |-> !ddr_ctrl_clk_en)
    else $error("memory enable in asynchronous mode");
  a_local_bus_div: assert property (local_bus_clock_out && local_bus_divider == 8'h03 ##1 local_bus_divider == 8'h03
    ##1 local_bus_divider == 8'h03 |-> !$past(local_bus_clock_out) ##1 local_bus_clock_out)
    else $error("local bus enable spacing wrong");
  a_pe_select: assert property (cap_q && pesel_q[0] |-> !packet_engine_clk_en[0] && !packet_engine_pll_ref_platform[0])
    else $error("packet engine selection wrong");
endmodule
`default_nettype wire

// *** bench/config_word_source.sv ***
// model of the configuration word source that feeds the clock decoder
// assumes a 100 MHz system reference clock when it picks pll range codes
`timescale 1ns/1ps
`default_nettype none
module config_word_source (
  input wire logic [4:0] plat,
  input wire logic [2:0][4:0] clm,
  input wire logic [3:0][3:0] csel,
  input wire logic sync,
  input wire logic [4:0] ddrm,
  input wire logic [1:0] pesel,
  input wire logic [3:0][2:0] sdm,
  input wire logic [7:0] sdd,
  input wire logic bad_rsv,
  input wire logic bad_cfg,
  output logic [clock_ratio_pkg::CFG_W-1:0] word
);
  // place a field, the first word bit is its msb
  function automatic logic [clock_ratio_pkg::CFG_W-1:0] put(input logic [clock_ratio_pkg::CFG_W-1:0] w,
    input int pos, input int n, input logic [4:0] v);
    logic [clock_ratio_pkg::CFG_W-1:0] r;
    r = w;
    for (int i = 0; i < n; i++)
    begin
      r[pos+i] = v[n-1-i];
    end
    return r;
  endfunction
  // memory pll range code at a 100 MHz reference
  function automatic logic [1:0] ddr_range(input logic s, input logic [4:0] m);
    if (s || m == 5'h0a)
      return clock_ratio_pkg::CFG_01;
    if (m == 5'h08 || m == 5'h09)
      return clock_ratio_pkg::CFG_10;
    return clock_ratio_pkg::CFG_11;
  endfunction
  // assemble the word from the chosen fields
  always_comb
  begin
    word = '0;
    word = put(word, clock_ratio_pkg::PLATFORM_MULT_POS, 5, plat); // link minimum left to the board
    for (int k = 0; k < 3; k++)
    begin
      word = put(word, clock_ratio_pkg::CLUSTER_MULT_POS + k * clock_ratio_pkg::CLUSTER_STRIDE, 5, clm[k]);
      word = put(word, clock_ratio_pkg::CLUSTER_MULT_POS + k * clock_ratio_pkg::CLUSTER_STRIDE
        + clock_ratio_pkg::CLUSTER_CFG_OFS, 2,
        {3'h0, ((clm[k] >= 5'h0a) ? 2'h2 : 2'h0) ^ {1'b0, bad_cfg && k == 0}}); // bad_cfg spoils pll one
    end
    for (int i = 0; i < 4; i++)
    begin
      word = put(word, clock_ratio_pkg::CORE_SEL_POS + 4 * i, 4, {1'b0, csel[i]});
      word = put(word, clock_ratio_pkg::SERDES_MULT_POS + 3 * i, 3, {2'h0, sdm[i]});
    end
    word = put(word, clock_ratio_pkg::DDR_CFG_POS, 2, {3'h0, ddr_range(sync, ddrm) ^ {1'b0, bad_cfg}}); // wrong code
    word = put(word, clock_ratio_pkg::DDR_MULT_POS, 5, ddrm);
    word = put(word, clock_ratio_pkg::PE_SEL_POS, 2, {3'h0, pesel});
    word = put(word, clock_ratio_pkg::SERDES_B1_DIV_POS, 5, sdd[7:3]);
    word = put(word, clock_ratio_pkg::SERDES_BN_DIV_POS, 3, {2'h0, sdd[2:0]});
    word[clock_ratio_pkg::DDR_SYNC_BIT] = sync;
    word[clock_ratio_pkg::DDR_RATE_BIT] = sync;
    word[clock_ratio_pkg::DDR_RSV_BIT] = bad_rsv;
  end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench for the power-up clock configuration decoder
// assumes the word source model in this folder and a 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] lb_div = 8'h00;
  logic [4:0] plat = 5'h05, ddrm = 5'h05;
  logic [2:0][4:0] clm = '0;
  logic [3:0][3:0] csel = '0;
  logic [3:0][2:0] sdm = '0;
  logic [1:0] pesel = 2'h0;
  logic [7:0] sdd = 8'h00;
  logic sync = 1'b0, bad_rsv = 1'b0, bad_cfg = 1'b0;
  logic [clock_ratio_pkg::CFG_W-1:0] word;
  logic cfg_ok, ddr_sm, ddr_en, lb_out, cerr;
  logic [4:0] plat_m, ddr_m, sd_b1;
  logic [2:0][4:0] cl_m;
  logic [2:0][1:0] cl_r;
  logic [3:0] c_src, c_half;
  logic [1:0] ddr_r, pe_sel, pe_en, pe_ref;
  logic [3:0][2:0] sd_m;
  logic [2:0] sd_bn;
  logic [7:0] eflags, eexp;
  int errors = 0, n_tests = 0, seed = 54812, cd, c0, c1, gap;
  // clock generator
  always #5 clk = ~clk;
  config_word_source src (.plat(plat), .clm(clm), .csel(csel), .sync(sync), .ddrm(ddrm), .pesel(pesel),
    .sdm(sdm), .sdd(sdd), .bad_rsv(bad_rsv), .bad_cfg(bad_cfg), .word(word));
  reset_config_clock_ratio_decoder DUT (.clk(clk), .rst_b(rst_b), .power_up_config_word(word),
    .local_bus_divider(lb_div), .config_valid(cfg_ok), .platform_pll_multiplier(plat_m),
    .cluster_pll_multiplier(cl_m), .cluster_pll_range_cfg(cl_r), .core_pll_source_select(c_src),
    .core_clock_halved(c_half), .ddr_sync_mode(ddr_sm), .ddr_pll_multiplier(ddr_m), .ddr_pll_range_cfg(ddr_r),
    .ddr_ctrl_clk_en(ddr_en), .local_bus_clock_out(lb_out), .packet_engine_clock_select(pe_sel),
    .packet_engine_clk_en(pe_en), .packet_engine_pll_ref_platform(pe_ref), .serdes_bank_multiplier(sd_m),
    .serdes_first_bank_divider(sd_b1), .serdes_bank_divider(sd_bn), .config_error_flags(eflags),
    .config_error(cerr));
  // expected decodes
  function automatic logic cl_ok(input logic [4:0] v);
    return v inside {8, 9, 10, 11, 12, 14, 15, 16, 17, 18, 20, 22};
  endfunction
  function automatic logic [4:0] exp_ddr(input logic s, input logic [4:0] v);
    if (s)
      return (v == 5'h01) ? 5'h01 : 5'h00;
    return (v inside {5, 6, 8, 9, 10, 12, 13, 16, 18, 19, 20, 24}) ? v : 5'h00;
  endfunction
  // memory pll range code a 100 MHz source writes, optionally spoiled
  function automatic logic [1:0] exp_rng(input logic s, input logic [4:0] v, input logic flip);
    logic [1:0] r;
    r = (s || v == 5'h0a) ? 2'h1 : (v == 5'h08 || v == 5'h09) ? 2'h2 : 2'h3;
    return r ^ {1'b0, flip};
  endfunction
  // a core on the other cluster's pll needs that pll strictly slower
  function automatic logic exp_order(input logic [2:0][4:0] m, input logic [3:0][3:0] s);
    logic [4:0] one;
    logic [4:0] two;
    logic r;
    one = cl_ok(m[0]) ? m[0] : 5'h00;
    two = cl_ok(m[1]) ? m[1] : 5'h00;
    r = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      r = r | (s[i][2] & (two >= one)) | (!s[i + 2][2] & (one >= two));
    end
    return r;
  endfunction
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence: random words with corner cases, one capture each
  initial
  begin
    repeat (12) tick();
    for (int it = 0; it < 40; it++)
    begin
      rst_b = 1'b0;
      plat = (it == 0) ? 5'h04 : (it == 1) ? 5'h09 : 5'h04 + (5'($random(seed)) & 5'h07);
      for (int k = 0; k < 3; k++)
        clm[k] = (it == 2) ? 5'h16 : (it == 3) ? 5'h08 : 5'($random(seed));
      for (int i = 0; i < 4; i++)
        csel[i] = (it == 4 && i == 2) ? 4'h2 : 4'($random(seed)) & 4'h5;
      sync = it[0];
      ddrm = (it == 5) ? 5'h18 : ($random(seed) & 1) ? 5'h01 : 5'($random(seed));
      pesel = 2'($random(seed));
      sdm = 12'($random(seed));
      sdd = 8'($random(seed));
      bad_rsv = (it == 6);
      bad_cfg = (it == 7 || it == 8);
      lb_div = 8'($random(seed)) & 8'h07;
      tick();
      `CHK(cfg_ok, 1'b0)
      tick();
      rst_b = 1'b1;
      tick();
      `CHK(cfg_ok, 1'b1)
      `CHK(plat_m, (plat >= 5 && plat <= 8) ? plat : 5'h00)
      for (int k = 0; k < 3; k++)
      begin
        `CHK(cl_m[k], cl_ok(clm[k]) ? clm[k] : 5'h00)
        `CHK(cl_r[k], ((clm[k] >= 5'h0a) ? 2'h2 : 2'h0) ^ {1'b0, bad_cfg && k == 0})
      end
      for (int i = 0; i < 4; i++)
        if (csel[i] inside {0, 1, 4, 5})
          `CHK({c_src[i], c_half[i]}, {csel[i][2], csel[i][0]})
      `CHK(ddr_sm, sync)
      `CHK(ddr_m, exp_ddr(sync, ddrm))
      `CHK(ddr_r, exp_rng(sync, ddrm, bad_cfg))
      `CHK(pe_sel, pesel)
      `CHK(pe_ref, ~pesel)
      `CHK(sd_m, sdm)
      `CHK(sd_b1, sdd[7:3])
      `CHK(sd_bn, sdd[2:0])
      eexp = 8'h00;
      eexp[0] = !(plat >= 5 && plat <= 8);
      eexp[1] = !(cl_ok(clm[0]) && cl_ok(clm[1]) && cl_ok(clm[2]));
      eexp[2] = bad_cfg;
      eexp[3] = (it == 4);
      eexp[4] = exp_order(clm, csel);
      eexp[5] = (exp_ddr(sync, ddrm) == 5'h00);
      eexp[6] = bad_cfg && (sync || exp_ddr(1'b0, ddrm) inside {6, 8, 9, 10, 12, 13, 16});
      eexp[7] = bad_rsv;
      `CHK(eflags, eexp)
      `CHK(eexp[4], eflags[4])
      `CHK(cerr, |eexp)
      cd = 0;
      c0 = 0;
      c1 = 0;
      repeat (20)
      begin
        tick();
        cd += (ddr_en === 1'b1);
        c0 += (pe_en[0] === 1'b1);
        c1 += (pe_en[1] === 1'b1);
      end
      `CHK(cd, sync ? 10 : 0)
      `CHK(c0, pesel[0] ? 0 : 10)
      `CHK(c1, pesel[1] ? 0 : 10)
      gap = 0;
      while (lb_out !== 1'b1)
      begin
        tick();
        gap++;
        if (gap > 20)
        begin
          errors++;
          print_verdict();
        end
      end
      gap = 0;
      do
      begin
        tick();
        gap++;
      end while (lb_out !== 1'b1 && gap < 20);
      `CHK(gap, (lb_div <= 1) ? 1 : int'(lb_div))
      plat = plat ^ 5'h1f;
      sync = ~sync;
      repeat (3) tick();
      `CHK(ddr_sm, ~sync)
      `CHK(plat_m, ((plat ^ 5'h1f) >= 5 && (plat ^ 5'h1f) <= 8) ? plat ^ 5'h1f : 5'h00)
    end
    print_verdict();
  end
endmodule
`default_nettype wire
